// File: hw/test_point_defines.svh
// ============================================================
// constants of the test point strap and debug port
// assumes a 20 MHz core clock and a 32-bit classic wishbone slave
`ifndef TEST_POINT_DEFINES_SVH
`define TEST_POINT_DEFINES_SVH

// ============================================================
// register byte offsets
`define REG_STRAP_CAPTURE 8'h00
`define REG_LINE_SELECT 8'h04
`define REG_VAR_DIVISOR 8'h08
`define REG_STATUS 8'h0c

// ============================================================
// reset values
`define LINE_SELECT_RESET 32'h0000_0000
`define VAR_DIVISOR_RESET 16'h0004
`define PULL_DOWN_RESET 8'hff

// ============================================================
// strap field positions and patterns
`define STRAP_LOW_MSB 2
`define STRAP_OPTION_LSB 3
`define STRAP_OPTION_MSB 6
`define STRAP_QUIET 3'h0
`define STRAP_CLOCK_DEBUG 3'h2

// ============================================================
// debug clock dividers: toggle every n cycles, rates keep 8:4:1 ratio
`define FAST_DIVISOR 16'h0001
`define HALF_DIVISOR 16'h0002
`define EIGHTH_DIVISOR 16'h0008

// ============================================================
// power sequencing times
`define CLOCK_MHZ 20
`define POWER_UP_NS 1000
`define POWER_DOWN_NS 1000
`define POWER_UP_CYCLES ((`POWER_UP_NS * `CLOCK_MHZ) / 1000)
`define POWER_DOWN_CYCLES ((`POWER_DOWN_NS * `CLOCK_MHZ) / 1000)

`endif

// File: hw/test_point_pkg.sv
// ============================================================
// types of the test point strap and debug port
// assumes test_point_defines.svh holds the numbers
package test_point_pkg;

    // what one test point line shows
    typedef enum logic [3:0] {
        SRC_HIZ,
        SRC_FAST,
        SRC_HALF,
        SRC_VAR,
        SRC_HIGH,
        SRC_LOW,
        SRC_EIGHTH
    } line_source_t;

    // projector power sequence
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_RISING,
        PWR_ON,
        PWR_FALLING
    } power_state_t;

    // captured strap word
    typedef struct packed {
        logic upper;
        logic [3:0] option;
        logic [2:0] low;
    } strap_t;

endpackage

// File: hw/pulse_divider.sv
// ============================================================
// one-cycle enable pulse every divisor cycles
// assumes a nonzero divisor; zero behaves as one
`timescale 1ns/100ps
module pulse_divider
    import test_point_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] divisor,
    output logic pulse
);

    logic [WIDTH-1:0] count;

    // ============================================================
    // count down and fire when reaching one
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
            pulse <= 1'b0;
        end
        else if (count <= WIDTH'(1))
        begin
            count <= divisor; // reload picks up divisor changes cleanly
            pulse <= 1'b1;
        end
        else
        begin
            count <= count - WIDTH'(1);
            pulse <= 1'b0;
        end
    end

endmodule

// File: hw/test_point_port.sv
// ============================================================
// test point strap capture, debug output select and power request
// assumes pins are synchronous to CLOCK and a classic wishbone master
`timescale 1ns/100ps
`include "test_point_defines.svh"
module test_point_port
    import test_point_pkg::*;
#(
    parameter int LINES = 8,
    parameter int DIV_WIDTH = 16
)
(
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic [7:0] TEST_POINT_LINES_I,
    output logic [7:0] TEST_POINT_LINES_O,
    output logic [7:0] TEST_POINT_LINES_OE,
    output logic [7:0] TEST_POINT_PULL_DOWN,
    input wire logic PROJECTOR_POWER_REQUEST,
    output logic POWER_ENABLE,
    output logic DISPLAY_ENABLE,
    output logic [3:0] MODE_OPTION,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O
);

    localparam int UP_CYCLES = (`POWER_UP_CYCLES < 1) ? 1 : `POWER_UP_CYCLES;
    localparam int DOWN_CYCLES = (`POWER_DOWN_CYCLES < 1) ? 1 : `POWER_DOWN_CYCLES;

    logic rst_meta;
    logic rst_n;
    logic captured;
    strap_t strap;
    logic [31:0] line_select;
    logic [DIV_WIDTH-1:0] var_divisor;
    logic fast_pulse;
    logic half_pulse;
    logic eighth_pulse;
    logic var_pulse;
    logic fast_clk;
    logic half_clk;
    logic eighth_clk;
    logic var_clk;
    logic [LINES-1:0] next_line_o;
    logic [LINES-1:0] next_line_oe;
    power_state_t power_state;
    logic [15:0] power_count;
    logic bus_req;

    // ============================================================
    // reset release through two flip-flops
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ============================================================
    // strap capture on the first edge after release, never again
    // pins are read in a clocked process so the async reset stays constant
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            captured <= 1'b0;
            strap <= '0;
        end
        else if (!captured)
        begin
            captured <= 1'b1;
            strap <= strap_t'(TEST_POINT_LINES_I);
        end
    end

    // ============================================================
    // weak pull-downs stay on for every line
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            TEST_POINT_PULL_DOWN <= `PULL_DOWN_RESET;
        else
            TEST_POINT_PULL_DOWN <= `PULL_DOWN_RESET;
    end

    // ============================================================
    // option bits follow the captured middle straps
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            MODE_OPTION <= 4'h0;
        else
            MODE_OPTION <= strap.option;
    end

    // ============================================================
    // line source table: strap default at capture, software after
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            line_select <= `LINE_SELECT_RESET;
        else if (!captured)
        begin
            if (TEST_POINT_LINES_I[`STRAP_LOW_MSB:0] == `STRAP_CLOCK_DEBUG)
                line_select <= {SRC_EIGHTH, SRC_HIGH, SRC_HIGH, SRC_LOW,
                                 SRC_HIGH, SRC_VAR, SRC_HALF, SRC_FAST};
            else
                line_select <= `LINE_SELECT_RESET;
        end
        else if (bus_req && WB_WE_I && WB_ADR_I == `REG_LINE_SELECT)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (WB_SEL_I[b])
                    line_select[b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
            end
        end
    end

    // ============================================================
    // variable clock divisor, low half-word only
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            var_divisor <= DIV_WIDTH'(`VAR_DIVISOR_RESET);
        else if (bus_req && WB_WE_I && WB_ADR_I == `REG_VAR_DIVISOR)
        begin
            if (WB_SEL_I[0])
                var_divisor[7:0] <= WB_DAT_I[7:0];
            if (WB_SEL_I[1])
                var_divisor[DIV_WIDTH-1:8] <= WB_DAT_I[DIV_WIDTH-1:8];
        end
    end

    // ============================================================
    // debug clock enables; 20 MHz core caps rates, ratios are kept
    pulse_divider #(.WIDTH(DIV_WIDTH)) u_fast (
        .clk(CLOCK),
        .rst_n(rst_n),
        .divisor(DIV_WIDTH'(`FAST_DIVISOR)),
        .pulse(fast_pulse)
    );
    pulse_divider #(.WIDTH(DIV_WIDTH)) u_half (
        .clk(CLOCK),
        .rst_n(rst_n),
        .divisor(DIV_WIDTH'(`HALF_DIVISOR)),
        .pulse(half_pulse)
    );
    pulse_divider #(.WIDTH(DIV_WIDTH)) u_eighth (
        .clk(CLOCK),
        .rst_n(rst_n),
        .divisor(DIV_WIDTH'(`EIGHTH_DIVISOR)),
        .pulse(eighth_pulse)
    );
    pulse_divider #(.WIDTH(DIV_WIDTH)) u_var (
        .clk(CLOCK),
        .rst_n(rst_n),
        .divisor(var_divisor),
        .pulse(var_pulse)
    );

    // ============================================================
    // square waves toggled by the enables
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fast_clk <= 1'b0;
            half_clk <= 1'b0;
            eighth_clk <= 1'b0;
            var_clk <= 1'b0;
        end
        else
        begin
            fast_clk <= fast_clk ^ fast_pulse;
            half_clk <= half_clk ^ half_pulse;
            eighth_clk <= eighth_clk ^ eighth_pulse;
            var_clk <= var_clk ^ var_pulse;
        end
    end

    // ============================================================
    // per-line source mux
    for (genvar i = 0; i < LINES; i++)
    begin : g_line
        always_comb
        begin
            next_line_o[i] = 1'b0;
            next_line_oe[i] = 1'b1;
            case (line_source_t'(line_select[i*4 +: 4]))
                SRC_FAST: next_line_o[i] = fast_clk;
                SRC_HALF: next_line_o[i] = half_clk;
                SRC_VAR: next_line_o[i] = var_clk;
                SRC_HIGH: next_line_o[i] = 1'b1;
                SRC_LOW: next_line_o[i] = 1'b0;
                SRC_EIGHTH: next_line_o[i] = eighth_clk;
                default: next_line_oe[i] = 1'b0;
            endcase
        end
    end

    // ============================================================
    // pins: no drive until the strap is taken
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            TEST_POINT_LINES_O <= 8'h00;
            TEST_POINT_LINES_OE <= 8'h00;
        end
        else if (!captured)
        begin
            TEST_POINT_LINES_O <= 8'h00;
            TEST_POINT_LINES_OE <= 8'h00;
        end
        else
        begin
            TEST_POINT_LINES_O <= next_line_o;
            TEST_POINT_LINES_OE <= next_line_oe;
        end
    end

    // ============================================================
    // power sequence from the request pin
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_state <= PWR_OFF;
            power_count <= 16'h0000;
            POWER_ENABLE <= 1'b0;
            DISPLAY_ENABLE <= 1'b0;
        end
        else
        begin
            case (power_state)
                PWR_OFF:
                    if (PROJECTOR_POWER_REQUEST)
                    begin
                        power_state <= PWR_RISING;
                        power_count <= 16'(UP_CYCLES);
                        POWER_ENABLE <= 1'b1;
                    end
                PWR_RISING:
                    if (!PROJECTOR_POWER_REQUEST)
                    begin
                        power_state <= PWR_FALLING;
                        power_count <= 16'(DOWN_CYCLES);
                    end
                    else if (power_count <= 16'h0001)
                    begin
                        power_state <= PWR_ON;
                        DISPLAY_ENABLE <= 1'b1;
                    end
                    else
                        power_count <= power_count - 16'h0001;
                PWR_ON:
                    if (!PROJECTOR_POWER_REQUEST)
                    begin
                        power_state <= PWR_FALLING;
                        power_count <= 16'(DOWN_CYCLES);
                        DISPLAY_ENABLE <= 1'b0;
                    end
                PWR_FALLING:
                    if (power_count <= 16'h0001)
                    begin
                        power_state <= PWR_OFF;
                        POWER_ENABLE <= 1'b0;
                    end
                    else
                        power_count <= power_count - 16'h0001;
                default:
                    power_state <= PWR_OFF;
            endcase
        end
    end

    // ============================================================
    // wishbone slave: one wait state, unmapped reads give zero
    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end
        else
        begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= 32'h0000_0000;
            if (bus_req && !WB_WE_I)
            begin
                case (WB_ADR_I)
                    `REG_STRAP_CAPTURE: WB_DAT_O <= {24'h000000, strap};
                    `REG_LINE_SELECT: WB_DAT_O <= line_select;
                    `REG_VAR_DIVISOR: WB_DAT_O <= 32'(var_divisor);
                    `REG_STATUS: WB_DAT_O <= {24'h000000, DISPLAY_ENABLE, POWER_ENABLE,
                                              power_state, strap.option};
                    default: WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// File: testbench/strap_board.sv
// ============================================================
// board around the test point pins: strap jumpers and weak pull-downs
// assumes drive and enable come straight from the port's pin outputs
`timescale 1ns/100ps
module strap_board
(
    input wire logic [7:0] straps,
    input wire logic [7:0] drive,
    input wire logic [7:0] oe,
    output logic [7:0] pins
);
    // a released line settles to its strap; no jumper leaves the pull-down
    always_comb
        for (int i = 0; i < 8; i++)
            pins[i] = oe[i] ? drive[i] : straps[i];
endmodule

// File: testbench/test_point_port_properties.sv
// ============================================================
// checker of the test point port: strap capture, debug lines, power
// assumes straps held steady for three edges after reset release
`timescale 1ns/100ps
module test_point_port_properties
(
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic [7:0] TEST_POINT_LINES_I,
    input wire logic [7:0] TEST_POINT_LINES_O,
    input wire logic [7:0] TEST_POINT_LINES_OE,
    input wire logic [7:0] TEST_POINT_PULL_DOWN,
    input wire logic PROJECTOR_POWER_REQUEST,
    input wire logic POWER_ENABLE,
    input wire logic DISPLAY_ENABLE,
    input wire logic [3:0] MODE_OPTION,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O
);
    logic [2:0] cnt;
    logic [7:0] cap;
    logic sw;
    logic dbg;
    // ============================================================
    // helpers
    // edges since release; the port samples pins at the third one
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            cnt <= 3'h0;
            cap <= 8'h00;
        end
        else
        begin
            if (cnt != 3'h5)
                cnt <= cnt + 3'h1;
            if (cnt == 3'h2)
                cap <= TEST_POINT_LINES_I;
        end
    end
    // once software writes the select, strap defaults no longer bind
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            sw <= 1'b0;
        else if (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_ADR_I == 8'h04)
            sw <= 1'b1;
    end
    assign dbg = (cnt == 3'h5) && !sw && (cap[2:0] == 3'h2);
    // ============================================================
    // properties
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);
    AST_IN_RESET: assert property (disable iff (1'b0)
        !ARST_N |-> TEST_POINT_LINES_OE == 8'h00) else $error("lines driven in reset");
    AST_PULL_DOWN: assert property (TEST_POINT_PULL_DOWN == 8'hff)
        else $error("pull-down off");
    AST_STRAP_ENABLES: assert property (cnt == 3'h5 && !sw |->
        TEST_POINT_LINES_OE == (cap[2:0] == 3'h2 ? 8'hff : 8'h00)) else $error("bad enables");
    AST_OPTION_HELD: assert property (cnt == 3'h5 |-> MODE_OPTION == cap[6:3])
        else $error("option not the captured one");
    AST_DEBUG_LEVELS: assert property (dbg |-> TEST_POINT_LINES_O[6:3] == 4'hd)
        else $error("debug levels wrong");
    AST_FAST_LINE: assert property (disable iff (!ARST_N || sw) dbg |=>
        TEST_POINT_LINES_O[0] != $past(TEST_POINT_LINES_O[0])) else $error("fast line stuck");
    AST_EIGHTH_LINE: assert property (disable iff (!ARST_N || sw)
        dbg && $rose(TEST_POINT_LINES_O[7]) |=> TEST_POINT_LINES_O[7] [*7] ##1
        !TEST_POINT_LINES_O[7]) else $error("slow line period wrong");
    AST_POWER_START: assert property (!POWER_ENABLE && PROJECTOR_POWER_REQUEST |=>
        POWER_ENABLE) else $error("power did not start");
    AST_DISPLAY_STOP: assert property (DISPLAY_ENABLE && !PROJECTOR_POWER_REQUEST |=>
        !DISPLAY_ENABLE) else $error("display did not stop");
    cover property (dbg);
    cover property (sw);
    cover property (DISPLAY_ENABLE);
endmodule

// File: testbench/tb_test_point_port.sv
// ============================================================
// testbench of the test point port: straps, debug lines, registers, power
// assumes the board model and the checker are compiled before it
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_test_point_port;
    logic CLOCK = 1'b0;
    // starts high so the drop at time zero is a real edge for the async reset
    logic ARST_N = 1'b1;
    logic PROJECTOR_POWER_REQUEST = 1'b0;
    logic WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
    logic [7:0] WB_ADR_I = 8'h00, straps = 8'h00;
    logic [3:0] WB_SEL_I = 4'h0, MODE_OPTION;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rexp;
    logic [7:0] TEST_POINT_LINES_I, TEST_POINT_LINES_O, TEST_POINT_LINES_OE, TEST_POINT_PULL_DOWN;
    logic POWER_ENABLE, DISPLAY_ENABLE, WB_ACK_O;
    logic [31:0] expq[$];
    logic [2:0] lows[4] = '{3'h0, 3'h2, 3'h5, 3'h2};
    int err_count = 0, n_compared = 0, seed = 71;
    test_point_port i_test_point_port (.*);
    strap_board i_strap_board (.straps(straps), .drive(TEST_POINT_LINES_O),
        .oe(TEST_POINT_LINES_OE), .pins(TEST_POINT_LINES_I));
    initial forever #25 CLOCK = ~CLOCK;
    // ============================================================
    // bus tasks: request held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge CLOCK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= w;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        WB_SEL_I <= s;
        do @(posedge CLOCK); while (WB_ACK_O !== 1'b1);
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask
    // read data compared against the oldest note at the ack edge
    always @(posedge CLOCK)
        if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0 && expq.size() > 0)
        begin
            rexp = expq.pop_front();
            `CHK("read data", rexp, WB_DAT_O)
        end
    // ============================================================
    // pin and power checks
    task automatic toggles(input int b, input int n, input int e);
        int c;
        logic p;
        c = 0;
        @(negedge CLOCK);
        p = TEST_POINT_LINES_I[b];
        repeat (n)
        begin
            @(negedge CLOCK);
            c += int'(TEST_POINT_LINES_I[b] !== p);
            p = TEST_POINT_LINES_I[b];
        end
        `CHK("toggles", e, c)
    endtask
    task automatic until_lvl(input bit disp, input logic v, input int e);
        int c;
        c = 0;
        do begin @(negedge CLOCK); c++; end
        while ((disp ? DISPLAY_ENABLE : POWER_ENABLE) !== v && c < 200);
        `CHK("power steps", e, c)
    endtask
    // one reset with a random option; pins flipped after capture
    task automatic session(input logic [2:0] low);
        logic [7:0] s;
        s = {1'b0, 4'($random(seed)), low};
        @(posedge CLOCK);
        ARST_N <= 1'b0;
        straps <= s;
        repeat (2) @(posedge CLOCK);
        ARST_N <= 1'b1;
        repeat (6) @(posedge CLOCK);
        straps <= ~s;
        @(negedge CLOCK);
        `CHK("option", s[6:3], MODE_OPTION)
        `CHK("enables", (low == 3'h2) ? 8'hff : 8'h00, TEST_POINT_LINES_OE)
        rd(8'h00, {24'h0, s});
        rd(8'h0c, {28'h0, s[6:3]});
        rd(8'h04, (low == 3'h2) ? 32'h6445_4321 : 32'h0);
        rd(8'h08, 32'h4);
        if (low == 3'h2)
        begin
            `CHK("levels", 4'hd, TEST_POINT_LINES_I[6:3])
            toggles(0, 32, 32);
            toggles(1, 32, 16);
            toggles(2, 32, 8);
            toggles(7, 64, 8);
            // faster variable clock; the read lets the old period run out
            wb(1'b1, 8'h08, 32'h0000_0002, 4'h3);
            rd(8'h08, 32'h2);
            toggles(2, 32, 16);
            wb(1'b1, 8'h04, 32'h4545_4545, 4'hf);
            wb(1'b1, 8'h04, 32'h0, 4'h1);
            rd(8'h04, 32'h4545_4500);
            @(negedge CLOCK);
            `CHK("sw lines", {6'h2a, ~s[1:0]}, TEST_POINT_LINES_I)
            `CHK("sw enables", 8'hfc, TEST_POINT_LINES_OE)
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ============================================================
    // main sequence and watchdog
    initial
    begin
        ARST_N <= 1'b0;
        for (int i = 0; i < 4; i++)
            session(lows[i]);
        wb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
        rd(8'h40, 32'h0);
        @(posedge CLOCK);
        PROJECTOR_POWER_REQUEST <= 1'b1;
        until_lvl(1'b0, 1'b1, 2);
        until_lvl(1'b1, 1'b1, 20);
        @(posedge CLOCK);
        PROJECTOR_POWER_REQUEST <= 1'b0;
        until_lvl(1'b1, 1'b0, 2);
        until_lvl(1'b0, 1'b0, 20);
        results();
    end
    initial
    begin
        repeat (8000) @(posedge CLOCK);
        err_count++;
        results();
    end
endmodule
bind test_point_port test_point_port_properties i_test_point_port_properties (.*);
